// file: rtl/adcsq_seq.sv
// Purpose: Calibration sequencer with APB registers
// Assumes: Master clock and raw modulator word come from outside pclk domain
// Notes:   Output period is a programmable count of master clock rises
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "adcsq_consts.svh"
module adcsq_seq
    import adcsq_pkg::*;
(
    // Clocking
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter side
    input  wire logic        mclk,
    input  wire logic [23:0] modulator_word,
    // Status
    output logic             conversion_valid_n,
    output logic             cal_busy
);
    adcsq_state_t state_ff, nxt_state;
    logic [2:0]  mode_ff, nxt_mode;
    logic        bipolar_ff, nxt_bipolar;
    logic [23:0] zs_ff, nxt_zs;
    logic [23:0] fs_ff, nxt_fs;
    logic [15:0] period_ff, nxt_period;
    logic [15:0] mdiv_ff, nxt_mdiv;
    logic [7:0]  mod_ff, nxt_mod;
    logic [3:0]  per_ff, nxt_per;
    logic [3:0]  bgcnt_ff, nxt_bgcnt;
    logic        rdy_n_ff, nxt_rdy_n;
    logic        pend_ff, nxt_pend;
    logic        fs_step_ff, nxt_fs_step;
    logic        load_ff, nxt_load;
    logic [23:0] raw_s1_ff, raw_s2_ff;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        busy_ff, nxt_busy;
    logic        mclk_rise;
    logic        out_tick;
    logic        mod_tick;
    logic        wr_en;
    logic        rd_en;
    logic        mode_wr;
    logic        hit;
    logic [23:0] corr_word;
    logic [23:0] data_ff, nxt_data;
    logic [23:0] span;
    logic [47:0] gain_q;

    // Master clock edges
    adcsq_sync u_mclk_sync
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .async_in   (mclk),
        .rise_pulse (mclk_rise)
    );

    // Coefficient correction of the raw word
    adcsq_corr u_corr
    (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .raw     (raw_s2_ff),
        .zs_coef (zs_ff),
        .fs_coef (fs_ff),
        .result  (corr_word)
    );

    // Raw word resynchronised, read only after two stages
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_s1_ff <= 24'h000000;
            raw_s2_ff <= 24'h000000;
        end
        else if (clk_en)
        begin
            raw_s1_ff <= modulator_word;
            raw_s2_ff <= raw_s1_ff;
        end
    end

    // Bus strobes
    assign wr_en   = psel & penable & pwrite & ~pready_ff;
    assign rd_en   = psel & penable & ~pwrite & ~pready_ff;
    assign mode_wr = wr_en & (paddr == `ADCSQ_OFF_MODE);

    // Output period and modulator cycle timing
    always_comb
    begin
        nxt_mdiv = mdiv_ff;
        nxt_mod  = mod_ff;
        out_tick = 1'b0;
        mod_tick = 1'b0;
        if (mclk_rise)
        begin
            if (mdiv_ff + 16'h0001 >= period_ff)
            begin
                nxt_mdiv = 16'h0000;
                out_tick = 1'b1;
            end
            else
                nxt_mdiv = mdiv_ff + 16'h0001;
            if (mod_ff + 8'h01 >= `ADCSQ_MOD_DIV)
            begin
                nxt_mod  = 8'h00;
                mod_tick = 1'b1;
            end
            else
                nxt_mod = mod_ff + 8'h01;
        end
    end

    // Gain mapping the measured span onto the full code, unity at 24'h800000
    always_comb
    begin
        span = raw_s2_ff - (bipolar_ff ? 24'h800000 : zs_ff);
        if (span == 24'h000000)
            gain_q = 48'h000000ffffff;
        else
            gain_q = 48'h7fffff800000 / {24'h000000, span};
    end

    // Sequencer and registers
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_mode    = mode_ff;
        nxt_bipolar = bipolar_ff;
        nxt_zs      = zs_ff;
        nxt_fs      = fs_ff;
        nxt_period  = period_ff;
        nxt_per     = per_ff;
        nxt_bgcnt   = bgcnt_ff;
        nxt_rdy_n   = rdy_n_ff;
        nxt_pend    = pend_ff;
        nxt_fs_step = fs_step_ff;
        nxt_load    = 1'b0;
        nxt_data    = data_ff;
        // Raise ready flag at the first output or modulator tick after a command,
        // so it is up before the step's own word even when a period is short
        if (pend_ff && (mod_tick || out_tick))
        begin
            nxt_rdy_n = 1'b1;
            nxt_pend  = 1'b0;
        end
        unique case (state_ff)
            ST_IDLE:
            begin
                if (out_tick)
                begin
                    nxt_load = 1'b1;
                    if (mode_ff == `ADCSQ_MD_BACKGND)
                    begin
                        nxt_state = ST_BGZ;
                        nxt_per   = `ADCSQ_BG_CAL_PER;
                    end
                end
            end
            ST_ZCAL:
            begin
                if (out_tick)
                begin
                    nxt_per = per_ff - 4'h1;
                    if (per_ff == 4'h1)
                    begin
                        // Zero point from analog input in both 010 and 100
                        nxt_zs = raw_s2_ff;
                        if (mode_ff == `ADCSQ_MD_SYS_OFS)
                        begin
                            nxt_state = ST_FCAL;
                            nxt_per   = `ADCSQ_SYS_STEP_PER;
                        end
                        else
                        begin
                            nxt_state = ST_CONV;
                            nxt_mode  = `ADCSQ_MD_NORMAL;
                            nxt_per   = `ADCSQ_CONV_PER;
                        end
                    end
                end
            end
            ST_FCAL:
            begin
                if (out_tick)
                begin
                    nxt_per = per_ff - 4'h1;
                    if (per_ff == 4'h1)
                    begin
                        // Span measured from zero point; bipolar from midscale
                        if (fs_step_ff && gain_q > 48'h000000ffffff)
                            nxt_fs = 24'hffffff;
                        else if (fs_step_ff)
                            nxt_fs = gain_q[23:0];
                        else
                            nxt_fs = `ADCSQ_INT_FS;
                        nxt_state = ST_CONV;
                        nxt_mode  = `ADCSQ_MD_NORMAL;
                        // System-offset conversion is the longer one
                        nxt_per   = fs_step_ff ? `ADCSQ_CONV_PER : `ADCSQ_OFS_CONV_PER;
                    end
                end
            end
            ST_CONV:
            begin
                if (out_tick)
                begin
                    nxt_per = per_ff - 4'h1;
                    if (per_ff == 4'h1)
                    begin
                        nxt_state = ST_IDLE;
                        nxt_load  = 1'b1;
                    end
                end
            end
            ST_BGZ:
            begin
                if (out_tick)
                begin
                    nxt_per = per_ff - 4'h1;
                    if (per_ff == 4'h1)
                    begin
                        nxt_zs    = raw_s2_ff;
                        nxt_bgcnt = bgcnt_ff + 4'h1;
                        nxt_state = ST_IDLE;
                    end
                end
            end
        endcase
        // Corrected word into the data register
        if (load_ff)
        begin
            nxt_data  = corr_word;
            nxt_rdy_n = 1'b0;
        end
        // Register writes
        if (wr_en && paddr == `ADCSQ_OFF_ZS_COEF)
            nxt_zs = pwdata[23:0];
        if (wr_en && paddr == `ADCSQ_OFF_FS_COEF)
            nxt_fs = pwdata[23:0];
        if (wr_en && paddr == `ADCSQ_OFF_PERIOD && pwdata[15:0] != 16'h0000)
            nxt_period = pwdata[15:0];
        if (mode_wr)
        begin
            nxt_mode    = pwdata[`ADCSQ_MODE_MSB:`ADCSQ_MODE_LSB];
            nxt_bipolar = pwdata[`ADCSQ_BIPOLAR_BIT];
            nxt_state   = ST_IDLE;
            nxt_load    = 1'b0;
            unique case (pwdata[`ADCSQ_MODE_MSB:`ADCSQ_MODE_LSB])
                `ADCSQ_MD_ZS_SYS, `ADCSQ_MD_SYS_OFS:
                begin
                    nxt_state   = ST_ZCAL;
                    nxt_per     = `ADCSQ_SYS_STEP_PER;
                    nxt_pend    = 1'b1;
                    nxt_fs_step = 1'b0;
                end
                `ADCSQ_MD_FS_SYS:
                begin
                    nxt_state   = ST_FCAL;
                    nxt_per     = `ADCSQ_SYS_STEP_PER;
                    nxt_pend    = 1'b1;
                    nxt_fs_step = 1'b1;
                end
                default:
                begin
                    nxt_pend = 1'b0;
                end
            endcase
        end
        nxt_busy = (nxt_state != ST_IDLE) && (nxt_state != ST_BGZ);
    end

    // APB answer, registered, one wait cycle in the access phase
    always_comb
    begin
        hit         = 1'b1;
        nxt_prdata  = 32'h00000000;
        nxt_pready  = psel & penable & ~pready_ff;
        unique case (paddr)
            `ADCSQ_OFF_MODE:    nxt_prdata = {28'h0, bipolar_ff, mode_ff};
            `ADCSQ_OFF_STATUS:  nxt_prdata = {20'h0, bgcnt_ff, 3'h0, state_ff[0],
                                              2'h0, busy_ff, rdy_n_ff};
            `ADCSQ_OFF_ZS_COEF: nxt_prdata = {8'h0, zs_ff};
            `ADCSQ_OFF_FS_COEF: nxt_prdata = {8'h0, fs_ff};
            `ADCSQ_OFF_DATA:    nxt_prdata = {8'h0, data_ff};
            `ADCSQ_OFF_RAW:     nxt_prdata = {8'h0, raw_s2_ff};
            `ADCSQ_OFF_PERIOD:  nxt_prdata = {16'h0, period_ff};
            default:            hit = 1'b0;
        endcase
        if (!rd_en)
            nxt_prdata = 32'h00000000;
        nxt_pslverr = (rd_en | wr_en) & ~hit;
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= ST_IDLE;
            mode_ff    <= `ADCSQ_MD_NORMAL;
            bipolar_ff <= 1'b0;
            zs_ff      <= `ADCSQ_ZS_RST;
            fs_ff      <= `ADCSQ_FS_RST;
            period_ff  <= `ADCSQ_PERIOD_RST;
            mdiv_ff    <= 16'h0000;
            mod_ff     <= 8'h00;
            per_ff     <= 4'h0;
            bgcnt_ff   <= 4'h0;
            rdy_n_ff   <= 1'b1;
            pend_ff    <= 1'b0;
            fs_step_ff <= 1'b0;
            load_ff    <= 1'b0;
            data_ff    <= 24'h000000;
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            busy_ff    <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff   <= nxt_state;
            mode_ff    <= nxt_mode;
            bipolar_ff <= nxt_bipolar;
            zs_ff      <= nxt_zs;
            fs_ff      <= nxt_fs;
            period_ff  <= nxt_period;
            mdiv_ff    <= nxt_mdiv;
            mod_ff     <= nxt_mod;
            per_ff     <= nxt_per;
            bgcnt_ff   <= nxt_bgcnt;
            rdy_n_ff   <= nxt_rdy_n;
            pend_ff    <= nxt_pend;
            fs_step_ff <= nxt_fs_step;
            load_ff    <= nxt_load;
            data_ff    <= nxt_data;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            busy_ff    <= nxt_busy;
        end
    end

    // Outputs straight from flip-flops
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign conversion_valid_n = rdy_n_ff;
    assign cal_busy           = busy_ff;
endmodule : adcsq_seq

// file: rtl/adcsq_consts.svh
// Purpose: Constants of the calibration sequencer
// Assumes: APB byte addressing, 32-bit data
// Notes:   Offsets are byte addresses
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
// Register byte offsets
`define ADCSQ_OFF_MODE      12'h000
`define ADCSQ_OFF_STATUS    12'h004
`define ADCSQ_OFF_ZS_COEF   12'h008
`define ADCSQ_OFF_FS_COEF   12'h00c
`define ADCSQ_OFF_DATA      12'h010
`define ADCSQ_OFF_RAW       12'h014
`define ADCSQ_OFF_PERIOD    12'h018
// Mode register fields
`define ADCSQ_MODE_LSB      0
`define ADCSQ_MODE_MSB      2
`define ADCSQ_BIPOLAR_BIT   3
// Calibration mode codes
`define ADCSQ_MD_NORMAL     3'h0
`define ADCSQ_MD_ZS_SYS     3'h2
`define ADCSQ_MD_FS_SYS     3'h3
`define ADCSQ_MD_SYS_OFS    3'h4
`define ADCSQ_MD_BACKGND    3'h5
// Step lengths in output periods
`define ADCSQ_SYS_STEP_PER  4'h3
`define ADCSQ_OFS_STEP_PER  4'h6
`define ADCSQ_CONV_PER      4'h1
`define ADCSQ_OFS_CONV_PER  4'h3
`define ADCSQ_BG_CAL_PER    4'h5
// Modulator divider of the master clock
`define ADCSQ_MOD_DIV       8'h80
// Reset values and internal full-scale coefficient
`define ADCSQ_ZS_RST        24'h000000
`define ADCSQ_FS_RST        24'h800000
`define ADCSQ_PERIOD_RST    16'h0010
`define ADCSQ_INT_FS        24'h7fffff
`endif

// file: rtl/adcsq_pkg.sv
// Purpose: Types of the calibration sequencer
// Assumes: One-hot state codes
// Notes:   Imported by adcsq_seq only
package adcsq_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ZCAL = 5'h02,
        ST_FCAL = 5'h04,
        ST_CONV = 5'h08,
        ST_BGZ  = 5'h10
    } adcsq_state_t;
endpackage : adcsq_pkg

// file: rtl/adcsq_sync.sv
// Purpose: Two-stage synchroniser and rising-edge finder
// Assumes: Input is asynchronous to pclk
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module adcsq_sync
(
    // Clocking
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // Signal
    input  wire logic async_in,
    output logic      rise_pulse
);
    logic s1_ff, s2_ff, s3_ff;
    logic nxt_s1, nxt_s2, nxt_s3;

    // Shift chain
    always_comb
    begin
        nxt_s1 = clk_en ? async_in : s1_ff;
        nxt_s2 = clk_en ? s1_ff : s2_ff;
        nxt_s3 = clk_en ? s2_ff : s3_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end

    // Edge from synchronised stages only
    assign rise_pulse = clk_en & s2_ff & ~s3_ff;
endmodule : adcsq_sync

// file: rtl/adcsq_corr.sv
// Purpose: Applies zero-scale and full-scale coefficients to a raw result
// Assumes: Full-scale coefficient is gain with 0x800000 as unity
// Notes:   Registered, one cycle of latency
`timescale 1ns/10ps
module adcsq_corr
(
    // Clocking
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // Operands
    input  wire logic [23:0] raw,
    input  wire logic [23:0] zs_coef,
    input  wire logic [23:0] fs_coef,
    // Result
    output logic [23:0]      result
);
    logic signed [25:0] diff;
    logic signed [50:0] prod;
    logic [23:0]        nxt_result;
    logic [23:0]        result_ff;

    // Subtract offset, then scale by the full-scale coefficient
    always_comb
    begin
        diff = $signed({2'b00, raw}) - $signed({2'b00, zs_coef});
        prod = 51'(diff) * $signed({27'h0, fs_coef});
        if (prod < 0)
            nxt_result = 24'h000000;
        else if (prod[50:23] > 28'h0ffffff)
            nxt_result = 24'hffffff;
        else
            nxt_result = prod[46:23];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_ff <= 24'h000000;
        else if (clk_en)
            result_ff <= nxt_result;
    end

    assign result = result_ff;
endmodule : adcsq_corr

// file: tb/adcsq_monitor.sv
// Purpose: Port checks of the calibration sequencer
// Assumes: Bound to adcsq_seq, single pclk domain
// Notes:   Command is a MODE write of a calibration code
`timescale 1ns/10ps
`include "adcsq_consts.svh"
module adcsq_monitor
(
    // Clocking
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Status
    input wire logic        conversion_valid_n,
    input wire logic        cal_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // First access cycle and calibration command
    logic acc;
    logic cmd;
    assign acc = psel && penable && !pready;
    assign cmd = acc && pwrite && paddr == `ADCSQ_OFF_MODE
                 && pwdata[2:0] inside {`ADCSQ_MD_ZS_SYS, `ADCSQ_MD_FS_SYS, `ADCSQ_MD_SYS_OFS};

    property p_ack; acc |=> pready; endproperty
    a_ack: assert property (p_ack) else $error("access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_src; pready |-> $past(psel && penable); endproperty
    a_src: assert property (p_src) else $error("ready without request");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rd0; !pready |-> prdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside answer");
    property p_unm; acc && paddr > `ADCSQ_OFF_PERIOD |=> pslverr; endproperty
    a_unm: assert property (p_unm) else $error("unmapped access not refused");
    // Cycles since a command while valid is still low
    logic [10:0] low_cnt_ff;
    logic [10:0] nxt_low_cnt;
    always_comb
    begin
        nxt_low_cnt = low_cnt_ff;
        if (cmd)
            nxt_low_cnt = 11'h001;
        else if (conversion_valid_n)
            nxt_low_cnt = 11'h000;
        else if (low_cnt_ff != 11'h000)
            nxt_low_cnt = low_cnt_ff + 11'h001;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_cnt_ff <= 11'h000;
        else
            low_cnt_ff <= nxt_low_cnt;
    end
    // One modulator cycle is about 1640 pclk cycles
    property p_start; low_cnt_ff <= 11'h6a4; endproperty
    a_start: assert property (p_start) else $error("valid not raised");
    property p_busy; cmd |-> ##[1:4] cal_busy; endproperty
    a_busy: assert property (p_busy) else $error("sequence not started");
    property p_hold; conversion_valid_n && cal_busy |=> conversion_valid_n || !cal_busy; endproperty
    a_hold: assert property (p_hold) else $error("valid low mid sequence");
endmodule : adcsq_monitor

// file: tb/adcsq_conv_model.sv
// Purpose: Converter side: master clock and modulator word
// Assumes: Master clock runs free at 64 ns
// Notes:   Word follows the level the host applies
`timescale 1ns/10ps
module adcsq_conv_model
(
    // Applied input level
    input  wire logic [23:0] level,
    // Converter side
    output logic             mclk,
    output logic [23:0]      modulator_word
);
    // Free running master clock
    initial mclk = 1'b0;
    always #32 mclk = ~mclk;

    // Word changes only when the host changes the level
    initial modulator_word = 24'h000000;
    always @(posedge mclk) modulator_word <= level;
endmodule : adcsq_conv_model

// file: tb/tb.sv
// Purpose: Register level test of the calibration sequencer
// Assumes: Default period of 16 master clocks, 205 pclk cycles
// Notes:   Times measured from the mode write
`timescale 1ns/10ps
`include "adcsq_consts.svh"
module tb;
    localparam int PER = 205;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        er;
    logic        mclk;
    logic        conversion_valid_n;
    logic        cal_busy;
    logic [23:0] modulator_word;
    logic [23:0] level;
    int          failures;
    int          tests_run;
    int          cyc;

    // Clock and cycle count
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    adcsq_seq dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk(mclk),
        .modulator_word(modulator_word), .conversion_valid_n(conversion_valid_n),
        .cal_busy(cal_busy));
    adcsq_conv_model u_conv (.level(level), .mclk(mclk), .modulator_word(modulator_word));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            failures++;
            wrap_up();
        end
    endtask : apb

    // Bounded wait for a valid level
    task automatic wait_vn(input logic v, input int lim);
        int n;
        n = 0;
        while (conversion_valid_n !== v && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim)
        begin
            failures++;
            wrap_up();
        end
    endtask : wait_vn

    // Time t lies in the n-th output period
    function automatic logic [31:0] in_win(input int t, input int n);
        return {31'h0, t >= (n - 1) * PER && t <= n * PER + 12};
    endfunction : in_win

    // Apply a level, then run one calibration command
    task automatic run_cal(input logic [23:0] lv, input logic [2:0] code, input int nc,
                           input int nt);
        int c0;
        int k;
        k = 0;
        level <= lv;
        repeat (300) @(posedge pclk);
        apb(1'b1, `ADCSQ_OFF_MODE, {29'h0, code});
        c0 = cyc;
        wait_vn(1'b1, 1700);
        do
        begin
            apb(1'b0, `ADCSQ_OFF_MODE, 32'h0);
            k++;
        end while (rd[2:0] !== 3'h0 && k < 1000);
        if (k >= 1000)
        begin
            failures++;
            wrap_up();
        end
        check(in_win(cyc - c0, nc), 32'h1, "mode clear time");
        wait_vn(1'b0, 4 * PER);
        check(in_win(cyc - c0, nt), 32'h1, "valid low time");
    endtask : run_cal

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        level = 24'h000000;
        failures = 0;
        tests_run = 0;
        cyc = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, coefficient access, unmapped place
        apb(1'b0, `ADCSQ_OFF_ZS_COEF, 32'h0);
        check(rd, {8'h0, `ADCSQ_ZS_RST}, "zs reset");
        apb(1'b0, `ADCSQ_OFF_FS_COEF, 32'h0);
        check(rd, {8'h0, `ADCSQ_FS_RST}, "fs reset");
        apb(1'b0, `ADCSQ_OFF_PERIOD, 32'h0);
        check(rd, {16'h0, `ADCSQ_PERIOD_RST}, "period reset");
        apb(1'b1, `ADCSQ_OFF_ZS_COEF, 32'hffabcdef);
        apb(1'b0, `ADCSQ_OFF_ZS_COEF, 32'h0);
        check(rd, 32'h00abcdef, "zs write");
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, er}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        // Normal conversions give a valid word before the command
        wait_vn(1'b0, 3 * PER);
        // Zero-scale then full-scale system steps
        run_cal(24'h001234, `ADCSQ_MD_ZS_SYS, 3, 4);
        apb(1'b0, `ADCSQ_OFF_ZS_COEF, 32'h0);
        check(rd, 32'h00001234, "zs from input");
        apb(1'b0, `ADCSQ_OFF_FS_COEF, 32'h0);
        check(rd, {8'h0, `ADCSQ_FS_RST}, "fs kept");
        apb(1'b0, `ADCSQ_OFF_DATA, 32'h0);
        check(rd, 32'h0, "zero-scale reading");
        run_cal(24'hc01234, `ADCSQ_MD_FS_SYS, 3, 4);
        apb(1'b0, `ADCSQ_OFF_ZS_COEF, 32'h0);
        check(rd, 32'h00001234, "zs kept");
        apb(1'b0, `ADCSQ_OFF_FS_COEF, 32'h0);
        check(rd, 32'h00aaaaaa, "fs from span");
        apb(1'b0, `ADCSQ_OFF_DATA, 32'h0);
        check(rd, 32'h00ffffff, "full-scale reading");
        // System-offset calibration
        run_cal(24'h000100, `ADCSQ_MD_SYS_OFS, 6, 9);
        apb(1'b0, `ADCSQ_OFF_ZS_COEF, 32'h0);
        check(rd, 32'h00000100, "offset zs");
        apb(1'b0, `ADCSQ_OFF_DATA, 32'h0);
        check(rd, 32'h0, "offset reading");
        // Background mode over thirteen periods
        apb(1'b1, `ADCSQ_OFF_FS_COEF, 32'h00654321);
        level <= 24'h000321;
        apb(1'b1, `ADCSQ_OFF_MODE, {29'h0, `ADCSQ_MD_BACKGND});
        repeat (13 * PER) @(posedge pclk);
        apb(1'b0, `ADCSQ_OFF_MODE, 32'h0);
        check(rd, 32'h5, "mode kept");
        apb(1'b0, `ADCSQ_OFF_STATUS, 32'h0);
        check({31'h0, rd[11:8] inside {4'h1, 4'h2, 4'h3}}, 32'h1, "bg rate");
        apb(1'b0, `ADCSQ_OFF_ZS_COEF, 32'h0);
        check(rd, 32'h00000321, "bg zs");
        apb(1'b0, `ADCSQ_OFF_FS_COEF, 32'h0);
        check(rd, 32'h00654321, "bg fs");
        apb(1'b1, `ADCSQ_OFF_MODE, 32'h0);
        apb(1'b0, `ADCSQ_OFF_MODE, 32'h0);
        check(rd, 32'h0, "bg left");
        wrap_up();
    end
endmodule : tb

bind adcsq_seq adcsq_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conversion_valid_n(conversion_valid_n),
    .cal_busy(cal_busy));
